// ==== cfg_hdr_pkg.sv ====
/*
 * constants and carrier types for the configuration header slice at
 * byte offsets 06h..0fh (status through self-test).
 * assumes: one package compiled ahead of the design module.
 */
package cfg_hdr_pkg;

	localparam logic [7:0]  OFS_STATUS_LO  = 8'h06;
	localparam logic [7:0]  OFS_STATUS_HI  = 8'h07;
	localparam logic [7:0]  OFS_REVISION   = 8'h08;
	localparam logic [7:0]  OFS_CLASS_PI   = 8'h09;
	localparam logic [7:0]  OFS_CLASS_SUB  = 8'h0a;
	localparam logic [7:0]  OFS_CLASS_BASE = 8'h0b;
	localparam logic [7:0]  OFS_CACHE_LINE = 8'h0c;
	localparam logic [7:0]  OFS_LATENCY    = 8'h0d;
	localparam logic [7:0]  OFS_HEADER     = 8'h0e;
	localparam logic [7:0]  OFS_SELF_TEST  = 8'h0f;

	localparam int BIT_FAST_B2B      = 7;
	localparam int BIT_DATA_PARITY   = 8;
	localparam int BIT_SIG_TGT_ABORT = 11;
	localparam int BIT_RCV_TGT_ABORT = 12;
	localparam int BIT_RCV_MST_ABORT = 13;
	localparam int BIT_SIG_SYS_ERR   = 14;
	localparam int BIT_DET_PARITY    = 15;
	localparam int BIT_ST_CAPABLE    = 7;
	localparam int BIT_ST_START      = 6;

	localparam logic [15:0] STATUS_RESET    = 16'h0280;
	localparam logic [15:0] STATUS_FIXED    = 16'h0280;
	localparam logic [15:0] STATUS_W1C_MASK = 16'hf900;
	localparam logic [1:0]  SEL_TIMING_MED  = 2'h1;
	// arbitrary value, not tied to any part
	localparam logic [7:0]  REVISION_DEFAULT = 8'h01;
	localparam logic [23:0] CLASS_RESET      = 24'h0c0200;
	localparam logic [7:0]  CACHE_LINE_VAL   = 8'h00;
	localparam logic [7:0]  LATENCY_RESET    = 8'h00;
	localparam logic [7:0]  HEADER_VAL       = 8'h00;
	localparam logic [7:0]  SELF_TEST_RESET  = 8'h80;
	localparam logic [3:0]  ST_CODE_RESET    = 4'h0;

	typedef enum logic [1:0] {
		SEL_FAST = 2'h0,
		SEL_MED  = 2'h1,
		SEL_SLOW = 2'h2
	} sel_timing_t;

	// host configuration byte access
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cfg_req_t;

	// bus events, single-cycle pulses in the link domain
	typedef struct packed {
		logic parity_seen;
		logic parity_det;
		logic sig_tgt_abort;
		logic rcv_tgt_abort;
		logic rcv_mst_abort;
		logic sys_err;
	} bus_evt_t;

	// local processor writes
	typedef struct packed {
		logic       class_wr;
		logic [23:0] class_val;
		logic       st_wr;
		logic       st_capable;
		logic       st_done;
		logic [3:0] st_code;
	} local_wr_t;

endpackage

// ==== cfg_hdr_status_self_test_control.sv ====
/*
 * configuration header slice 06h..0fh: status flags, ids, latency timer,
 * header type and self-test handshake. ref_clk carries host config access
 * and the local processor view; link_clk carries bus event pulses.
 * assumes: events are one link_clk pulse each, spaced >= 4 link clocks.
 */
//
// Function
// - writing one clears a status flag; zero leaves it; reads are plain
// - status bit 7 is fixed one: fast back-to-back target capable
// - bit 8 sets on parity error seen while parity response enabled
// - status bits 10:9 read fixed medium select timing code 01
// - target select asserted no later than medium timing outside config
// - bit 11 sets when the device ends a target cycle with abort
// - bit 12 sets when a master cycle is target aborted
// - bit 13 sets when the device ends a master cycle with master abort
// - bit 14 sets whenever the device drives system error
// - bit 15 sets on any parity error, enable or not
// - revision register reads its code, host writes ignored
// - class code 0c0200 writable only from the local side
// - cache line size reads zero, all writes ignored
// - latency timer resets zero, host writable, limits master bursts
// - header type reads zero, single function, host writes ignored
// - self-test resets 80h; host writes only bit 6; bits 5:4 zero
// - host writing one to bit 6 raises local self-test interrupt
// - local processor clears bit 6 when the self test finishes
// - bits 3:0 hold the result: zero pass, nonzero failure code
// - self-test bit 7 resets one (self test supported); local side may rewrite it
`timescale 1ns/10ps

module cfg_hdr_status_self_test_control
	import cfg_hdr_pkg::*;
#(
	parameter logic [7:0] REVISION_CODE = REVISION_DEFAULT
) (
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	input  wire logic                 link_clk,
	input  wire cfg_hdr_pkg::cfg_req_t  cfg_req,
	input  wire logic                 parity_resp_en,
	input  wire cfg_hdr_pkg::bus_evt_t  bus_evt,
	input  wire cfg_hdr_pkg::local_wr_t local_wr,
	output logic [7:0]                cfg_rdata,
	output logic                      cfg_rvalid,
	output logic [15:0]               status_view,
	output logic [7:0]                self_test_view,
	output logic                      self_test_irq,
	output logic [7:0]                latency_limit,
	output logic [1:0]                sel_timing
);
	import cfg_hdr_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// event crossing: toggle per event on link_clk, 2ff + edge on ref_clk

	localparam int NEVT = 6;

	logic [NEVT-1:0] evt_tgl_ff;
	logic [NEVT-1:0] evt_s1_ff;
	logic [NEVT-1:0] evt_s2_ff;
	logic [NEVT-1:0] evt_s3_ff;
	logic [NEVT-1:0] evt_pulse;
	logic [NEVT-1:0] evt_raw;
	logic            pe_s1_ff;
	logic            parity_en_link_ff;

	// parity-seen only counts while response is enabled
	assign evt_raw = {bus_evt.parity_seen & parity_en_link_ff,
	                  bus_evt.parity_det, bus_evt.sig_tgt_abort,
	                  bus_evt.rcv_tgt_abort, bus_evt.rcv_mst_abort,
	                  bus_evt.sys_err};

	// enable is a level; synchronise into the link domain
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			pe_s1_ff          <= 1'b0;
			parity_en_link_ff <= 1'b0;
		end else begin
			pe_s1_ff          <= parity_resp_en;
			parity_en_link_ff <= pe_s1_ff;
		end
	end

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst)
			evt_tgl_ff <= '0;
		else
			evt_tgl_ff <= evt_tgl_ff ^ evt_raw;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			evt_s1_ff <= '0;
			evt_s2_ff <= '0;
			evt_s3_ff <= '0;
		end else begin
			evt_s1_ff <= evt_tgl_ff;
			evt_s2_ff <= evt_s1_ff;
			evt_s3_ff <= evt_s2_ff;
		end
	end

	assign evt_pulse = evt_s2_ff ^ evt_s3_ff;

	////////////////////////////////////////////////////////////////////////
	// host write decode

	function automatic logic hit(input cfg_req_t r, input logic [7:0] a);
		hit = r.wr && (r.addr == a);
	endfunction

	logic [15:0] clr_mask;
	logic [15:0] set_mask;

	always_comb begin
		clr_mask = '0;
		if (hit(cfg_req, OFS_STATUS_LO))
			clr_mask[7:0] = cfg_req.wdata;
		else if (hit(cfg_req, OFS_STATUS_HI))
			clr_mask[15:8] = cfg_req.wdata;
		clr_mask = clr_mask & STATUS_W1C_MASK;
	end

	always_comb begin
		set_mask = '0;
		set_mask[BIT_DATA_PARITY]   = evt_pulse[5];
		set_mask[BIT_DET_PARITY]    = evt_pulse[4];
		set_mask[BIT_SIG_TGT_ABORT] = evt_pulse[3];
		set_mask[BIT_RCV_TGT_ABORT] = evt_pulse[2];
		set_mask[BIT_RCV_MST_ABORT] = evt_pulse[1];
		set_mask[BIT_SIG_SYS_ERR]   = evt_pulse[0];
	end

	////////////////////////////////////////////////////////////////////////
	// status flags

	logic [15:0] flags_ff;
	logic [15:0] nxt_flags;

	// set applied after clear so a coincident event survives
	assign nxt_flags = ((flags_ff & ~clr_mask) | set_mask)
	                   & STATUS_W1C_MASK;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			flags_ff <= STATUS_RESET & STATUS_W1C_MASK;
		else
			flags_ff <= nxt_flags;
	end

	logic [15:0] status_word;
	// bit 7 and medium select timing are hard-wired
	assign status_word = flags_ff | STATUS_FIXED;

	////////////////////////////////////////////////////////////////////////
	// class code, local side only

	logic [23:0] class_ff;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			class_ff <= CLASS_RESET;
		else if (local_wr.class_wr)
			class_ff <= local_wr.class_val;
	end

	////////////////////////////////////////////////////////////////////////
	// latency timer

	logic [7:0] latency_ff;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			latency_ff <= LATENCY_RESET;
		else if (hit(cfg_req, OFS_LATENCY))
			latency_ff <= cfg_req.wdata;
	end

	////////////////////////////////////////////////////////////////////////
	// self-test register

	logic       st_cap_ff;
	logic       st_start_ff;
	logic [3:0] st_code_ff;
	logic       host_start;

	assign host_start = hit(cfg_req, OFS_SELF_TEST)
	                    && cfg_req.wdata[BIT_ST_START];

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			st_cap_ff <= SELF_TEST_RESET[BIT_ST_CAPABLE];
		else if (local_wr.st_wr)
			st_cap_ff <= local_wr.st_capable;
	end

	// result code stays until the local side rewrites it
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			st_code_ff <= ST_CODE_RESET;
		else if (local_wr.st_wr)
			st_code_ff <= local_wr.st_code;
	end

	// host start wins over a coincident local done
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			st_start_ff <= SELF_TEST_RESET[BIT_ST_START];
		else if (host_start)
			st_start_ff <= 1'b1;
		else if (local_wr.st_wr && local_wr.st_done)
			st_start_ff <= 1'b0;
	end

	logic [7:0] st_word;
	assign st_word = {st_cap_ff, st_start_ff, 2'b00, st_code_ff};

	// one-cycle interrupt pulse to the local processor
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			self_test_irq <= 1'b0;
		else
			self_test_irq <= host_start;
	end

	////////////////////////////////////////////////////////////////////////
	// read mux; unmapped offsets read zero

	logic [7:0] rd_mux;

	always_comb begin
		if (cfg_req.addr == OFS_STATUS_LO)
			rd_mux = status_word[7:0];
		else if (cfg_req.addr == OFS_STATUS_HI)
			rd_mux = status_word[15:8];
		else if (cfg_req.addr == OFS_REVISION)
			rd_mux = REVISION_CODE;
		else if (cfg_req.addr == OFS_CLASS_PI)
			rd_mux = class_ff[7:0];
		else if (cfg_req.addr == OFS_CLASS_SUB)
			rd_mux = class_ff[15:8];
		else if (cfg_req.addr == OFS_CLASS_BASE)
			rd_mux = class_ff[23:16];
		else if (cfg_req.addr == OFS_CACHE_LINE)
			rd_mux = CACHE_LINE_VAL;
		else if (cfg_req.addr == OFS_LATENCY)
			rd_mux = latency_ff;
		else if (cfg_req.addr == OFS_HEADER)
			rd_mux = HEADER_VAL;
		else if (cfg_req.addr == OFS_SELF_TEST)
			rd_mux = st_word;
		else
			rd_mux = 8'h00;
	end

	// data held at zero between reads so stale bytes never leak
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			cfg_rdata <= 8'h00;
		else
			cfg_rdata <= cfg_req.rd ? rd_mux : 8'h00;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			cfg_rvalid <= 1'b0;
		else
			cfg_rvalid <= cfg_req.rd;
	end

	////////////////////////////////////////////////////////////////////////
	// registered views for the rest of the adapter

	// views lag the registers by one cycle; readers must allow for it
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			status_view <= STATUS_RESET;
		else
			status_view <= status_word;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			self_test_view <= SELF_TEST_RESET;
		else
			self_test_view <= st_word;
	end

	// burst logic counts against this limit in bus clocks
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			latency_limit <= LATENCY_RESET;
		else
			latency_limit <= latency_ff;
	end

	// target logic must decode no slower than this class
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			sel_timing <= SEL_TIMING_MED;
		else
			sel_timing <= SEL_MED;
	end

endmodule

// ==== cfg_hdr_asserts.sv ====
/* checks on the config header slice ports.
 * assumes: bound onto cfg_hdr_status_self_test_control. */
`timescale 1ns/10ps
module cfg_hdr_asserts
	import cfg_hdr_pkg::*;
#(
	parameter logic [7:0] REVISION_CODE = REVISION_DEFAULT
) (
	input wire logic                  ref_clk,
	input wire logic                  rst,
	input wire cfg_hdr_pkg::cfg_req_t cfg_req,
	input wire logic [7:0]            cfg_rdata,
	input wire logic                  cfg_rvalid,
	input wire logic [15:0]           status_view,
	input wire logic [7:0]            self_test_view,
	input wire logic                  self_test_irq,
	input wire logic [7:0]            latency_limit,
	input wire logic [1:0]            sel_timing
);
default clocking @(posedge ref_clk); endclocking
default disable iff (rst);
sequence st_start;
	cfg_req.wr && cfg_req.addr == OFS_SELF_TEST && cfg_req.wdata[6];
endsequence
sequence rd_of(logic [7:0] a);
	cfg_req.rd && cfg_req.addr == a;
endsequence
fixed_bits_a: assert property (
	status_view[7:0] == 8'h80 && status_view[10:9] == SEL_TIMING_MED)
	else $error("status fixed bits wrong");
sel_med_a: assert property (sel_timing == SEL_TIMING_MED)
	else $error("select timing not medium");
rd_valid_a: assert property (cfg_req.rd |=> cfg_rvalid)
	else $error("read not answered");
rev_read_a: assert property (
	rd_of(OFS_REVISION) |=> cfg_rdata == REVISION_CODE)
	else $error("revision read wrong");
zero_read_a: assert property (
	rd_of(OFS_CACHE_LINE) |=> cfg_rdata == 8'h00)
	else $error("cache line read nonzero");
hdr_read_a: assert property (
	rd_of(OFS_HEADER) |=> cfg_rdata == HEADER_VAL)
	else $error("header type read wrong");
irq_start_a: assert property (
	st_start |=> self_test_irq ##1 self_test_view[6])
	else $error("self test start lost");
irq_cause_a: assert property (
	self_test_irq |-> $past(cfg_req.wr) &&
		$past(cfg_req.addr) == OFS_SELF_TEST &&
		$past(cfg_req.wdata[BIT_ST_START]))
	else $error("self test irq without start");
st_rsvd_a: assert property (self_test_view[5:4] == 2'h0)
	else $error("self test reserved bits set");
lat_wr_a: assert property (
	cfg_req.wr && cfg_req.addr == OFS_LATENCY
		|-> ##2 latency_limit == $past(cfg_req.wdata, 2))
	else $error("latency write lost");
endmodule
bind cfg_hdr_status_self_test_control cfg_hdr_asserts #(
	.REVISION_CODE(REVISION_CODE)
) u_chk (.ref_clk, .rst, .cfg_req, .cfg_rdata, .cfg_rvalid,
	.status_view, .self_test_view, .self_test_irq, .latency_limit,
	.sel_timing);

// ==== bus_side_model.sv ====
/* far side: bus event pulses on the link clock, parity response level.
 * assumes: link_clk comes from the bench. */
`timescale 1ns/10ps
module bus_side_model
	import cfg_hdr_pkg::*;
(
	input wire logic               link_clk,
	output cfg_hdr_pkg::bus_evt_t  bus_evt,
	output logic                   parity_resp_en
);
initial begin
	bus_evt = '0;
	parity_resp_en = 1'b0;
end
// quiet afterwards so that like events never merge
task automatic fire(input bus_evt_t m);
	@(posedge link_clk);
	#1 bus_evt = m;
	@(posedge link_clk);
	#1 bus_evt = '0;
	repeat (5) @(posedge link_clk);
endtask
// enable has to settle in the link domain first
task automatic set_parity_resp(input logic en);
	parity_resp_en = en;
	repeat (3) @(posedge link_clk);
endtask
endmodule

// ==== tb.sv ====
/* self-checking bench for the config header slice against a mirror.
 * assumes: package, design, checker and far side model compiled. */
`timescale 1ns/10ps
module tb;
import cfg_hdr_pkg::*;
logic        ref_clk = 1'b0;
logic        link_clk = 1'b0;
logic        rst = 1'b1;
cfg_req_t    cfg_req = '0;
local_wr_t   local_wr = '0;
bus_evt_t    bus_evt;
logic        parity_resp_en, cfg_rvalid, self_test_irq;
logic [7:0]  cfg_rdata, self_test_view, latency_limit, b;
logic [15:0] status_view;
logic [1:0]  sel_timing;
int          n_errors = 0, comparisons = 0;
int          m_st = 'h280, m_lat = 0, m_self_test_control = 'h80, m_cls = 'hc0200;
int          evt_bit[6] = '{14, 13, 12, 11, 15, 8};
always #10 ref_clk = ~ref_clk;
always #7.5 link_clk = ~link_clk;
cfg_hdr_status_self_test_control u_dut (.ref_clk, .rst, .link_clk, .cfg_req,
	.parity_resp_en, .bus_evt, .local_wr, .cfg_rdata, .cfg_rvalid,
	.status_view, .self_test_view, .self_test_irq, .latency_limit,
	.sel_timing);
bus_side_model u_far (.link_clk, .bus_evt, .parity_resp_en);
////////////////////////////////////////////////////////////////////////
function automatic int mdl(input int a);
	case (a)
	6: return m_st & 255;
	7: return m_st >> 8;
	8: return REVISION_DEFAULT;
	9, 10, 11: return (m_cls >> (8 * (a - 9))) & 255;
	13: return m_lat;
	15: return m_self_test_control;
	default: return 0;
	endcase
endfunction
task automatic chk(input string what, input logic [15:0] exp, got);
	comparisons++;
	if (got !== exp) begin
		n_errors++;
		$display("[ERR] %s exp %h got %h", what, exp, got);
	end
endtask
// one idle cycle after each access keeps drives one per time step
task automatic wr(input logic [7:0] a, d);
	cfg_req = '{1'b1, 1'b0, a, d};
	@(posedge ref_clk);
	#1 cfg_req = '0;
	if (a == 7) m_st &= ~((d & 8'hf9) * 256);
	if (a == 13) m_lat = d;
	if (a == 15 && d[6]) m_self_test_control |= 'h40;
	if (a == 15 && d[6]) chk("irq", 16'h1, 16'(self_test_irq));
	@(posedge ref_clk);
	#1;
endtask
task automatic rd(input logic [7:0] a);
	cfg_req = '{1'b0, 1'b1, a, 8'h00};
	@(posedge ref_clk);
	#1 cfg_req = '0;
	chk("rvalid", 16'h1, 16'(cfg_rvalid));
	chk("rdata", 16'(mdl(a)), 16'(cfg_rdata));
	@(posedge ref_clk);
	#1;
endtask
task automatic rd_all;
	for (int a = 5; a <= 16; a++) rd(8'(a));
endtask
task automatic loc(input local_wr_t v);
	local_wr = v;
	@(posedge ref_clk);
	#1 local_wr = '0;
	if (v.class_wr) m_cls = v.class_val;
	if (v.st_wr) m_self_test_control = (v.st_capable << 7) | v.st_code |
		(v.st_done ? 0 : m_self_test_control & 'h40);
	@(posedge ref_clk);
	#1;
endtask
task automatic end_of_test;
	$display("comparisons %0d mismatches %0d", comparisons, n_errors);
	if (n_errors == 0 && comparisons > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
endtask
////////////////////////////////////////////////////////////////////////
initial begin
	#200000;
	n_errors++;
	end_of_test();
end
initial begin
	b = 8'($urandom(26));
	repeat (2) @(posedge ref_clk);
	#1 rst = 1'b0;
	rd_all();
	chk("sel_timing", 16'(SEL_TIMING_MED), 16'(sel_timing));
	$display("test reset values done");
	for (int a = 5; a <= 16; a++)
		wr(8'(a), a == 15 ? 8'h00 : 8'($urandom));
	rd_all();
	$display("test host writes done");
	for (int en = 0; en < 2; en++) begin
		u_far.set_parity_resp(en[0]);
		for (int i = 0; i < 6; i++) begin
			u_far.fire(bus_evt_t'(6'h01 << i));
			repeat (3) @(posedge ref_clk);
			#1;
			if (i != 5 || en) m_st |= 1 << evt_bit[i];
			rd(7);
			wr(7, 8'h00);
			chk("status_view", 16'(m_st), status_view);
			wr(7, 8'hff);
			rd(7);
		end
	end
	$display("test bus events done");
	wr(15, 8'h40);
	wr(15, 8'h8f);
	rd(15);
	loc('{1'b0, 24'h0, 1'b1, 1'b1, 1'b1, b[3:0]});
	rd(15);
	chk("self_test_view", 16'(m_self_test_control), 16'(self_test_view));
	loc('{1'b1, 24'($urandom), 1'b0, 1'b0, 1'b0, 4'h0});
	for (int a = 9; a <= 11; a++) rd(8'(a));
	wr(13, 8'h40);
	chk("latency_limit", 16'h40, 16'(latency_limit));
	$display("test self test and local done");
	end_of_test();
end
endmodule
